// File: design/sleep_wake_device.sv
`timescale 1ns/1ps
// What this block does
// - Host arms pin sleep with config 1
// - Armed mode 1: sleep when request high
// - Request low over 50ms exits sleep
// - Asleep: ignore commands except attention in mode 2, still report events
// - Host arms auto sleep with config 2
// - Mode 2: sleep after idle timeout, 5s
// - Mode 2 wakes by answering attention
// - Mode 2 ignores request pin for wake
// - Events while host sleeps drive wake line
// - USB host must support suspend/resume
// - USB suspend puts device to sleep
// - USB resume wakes device
// - Power key or low battery shuts down
// - Interrupt, timer or data wakes sleep
// - Sleep only on request, no 30s auto; mode 2 also sleeps on its idle timeout
// - New message: wake line low 120ms
// - Wake line idles high
module sleep_wake_device
  import sleep_wake_pkg::*;
#(
  parameter int unsigned DTR_LOW_N   = DTR_LOW_CYC,      // Exit hold, cycles
  parameter int unsigned RING_N      = RING_PULSE_CYC,   // Ring pulse, cycles
  parameter int unsigned IDLE_INIT_N = IDLE_DEFAULT_CYC  // Default idle timeout
) (
  input  wire logic  i_ref_clk,    // 50 MHz clock
  input  wire logic  i_rstn,       // Async reset, active low
  sleep_wake_if.device link,       // Pins toward host
  input  wire logic  i_power_on,   // Boot request pulse while off
  input  wire logic  i_batt_low,   // Supply below shutdown threshold
  input  wire logic  i_wake_event, // GPIO interrupt or timer expiry
  input  wire logic  i_msg_rx,     // New message or network data pulse
  output logic       o_event_urc,  // Unsolicited report pulse
  output logic       o_asleep,     // Device in sleep
  output logic       o_powered     // Device not off
);
  import sleep_wake_pkg::*;

  // Power state group: state, arming, limits, timers and strobes
  pwr_state_type    state_ff, nxt_state;
  logic [1:0]       mode_ff, nxt_mode;
  logic [CNT_W-1:0] idle_lim_ff, nxt_idle_lim;
  logic [CNT_W-1:0] idle_cnt_ff, nxt_idle_cnt;
  logic [CNT_W-1:0] dtr_cnt_ff, nxt_dtr_cnt;
  logic [CNT_W-1:0] ring_cnt_ff, nxt_ring_cnt;
  logic             resp_ff, nxt_resp;
  logic             urc_ff, nxt_urc;
  // Synchronisers and edge detectors
  logic             dtr_s1_ff, dtr_s2_ff, key_s1_ff, key_s2_ff, key_d_ff;
  logic             usb_s1_ff, usb_s2_ff, bat_s1_ff, bat_s2_ff;
  logic             usb_d_ff;
  logic             key_edge, usb_rise, usb_fall, attn;

  // Counters hold at all ones rather than wrap, so a pin left low for a
  // very long time never reads as a fresh short run
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    if (v == '1) begin
      return v;
    end
    return v + 1'b1;
  endfunction : sat_inc

  // Request, key, suspend and battery inputs pass two flip-flops; reset values match the idle
  // pin levels so that no false edge follows reset
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dtr_s1_ff <= 1'b0;
      dtr_s2_ff <= 1'b0;
      key_s1_ff <= 1'b0;
      key_s2_ff <= 1'b0;
      key_d_ff  <= 1'b0;
      usb_s1_ff <= 1'b0;
      usb_s2_ff <= 1'b0;
      usb_d_ff  <= 1'b0;
      bat_s1_ff <= 1'b0;
      bat_s2_ff <= 1'b0;
    end else begin
      dtr_s1_ff <= link.sleep_req;
      dtr_s2_ff <= dtr_s1_ff;
      key_s1_ff <= link.power_key_pin;
      key_s2_ff <= key_s1_ff;
      key_d_ff  <= key_s2_ff;
      usb_s1_ff <= link.usb_suspend;
      usb_s2_ff <= usb_s1_ff;
      usb_d_ff  <= usb_s2_ff;
      bat_s1_ff <= i_batt_low;
      bat_s2_ff <= bat_s1_ff;
    end
  end

  // Edges act once; a held key or suspend level does not repeat its effect
  assign key_edge = key_s2_ff & ~key_d_ff;
  assign usb_rise = usb_s2_ff & ~usb_d_ff;
  assign usb_fall = ~usb_s2_ff & usb_d_ff;
  // Attention is the only command heard while asleep, and only in mode 2
  assign attn     = link.cmd_valid && (link.cmd_code == CMD_ATTN);

  // Power state, sleep mode arming, idle and exit timers
  always_comb begin
    nxt_state    = state_ff;
    nxt_mode     = mode_ff;
    nxt_idle_lim = idle_lim_ff;
    nxt_resp     = 1'b0;
    nxt_urc      = 1'b0;
    // Any strobe counts as serial activity, even one refused in sleep
    nxt_idle_cnt = link.cmd_valid ? '0 : sat_inc(idle_cnt_ff);
    nxt_dtr_cnt  = dtr_s2_ff ? '0 : sat_inc(dtr_cnt_ff);
    // Commands are taken only while awake
    if (state_ff == PWR_NORMAL && link.cmd_valid) begin
      nxt_resp = 1'b1;
      if (link.cmd_code == CMD_SLEEP_CFG) begin
        nxt_mode = link.cmd_arg;
      end else if (link.cmd_code == CMD_TIMEOUT_CFG) begin
        nxt_idle_lim = link.cmd_timeout;
      end
    end
    // Reports go out in any powered state, asleep or not
    if ((state_ff != PWR_OFF) && i_msg_rx) begin
      nxt_urc = 1'b1;
    end
    unique case (state_ff)
      // Off: arming is cleared so that a boot starts unarmed
      PWR_OFF: begin
        nxt_mode     = SLEEP_CFG_OFF;
        nxt_idle_lim = IDLE_INIT_N;
        if (i_power_on) begin
          nxt_state = PWR_NORMAL;
        end
      end
      // Shutdown outranks sleep; sleep is entered on USB suspend, the mode 1 pin or the mode 2 idle timeout
      PWR_NORMAL: begin
        if (key_edge || bat_s2_ff) begin
          nxt_state = PWR_OFF;
        end else if (usb_rise) begin
          nxt_state = PWR_SLEEP;
        end else if (mode_ff == SLEEP_CFG_PIN && dtr_s2_ff) begin
          nxt_state = PWR_SLEEP;
        end else if (mode_ff == SLEEP_CFG_AUTO && idle_cnt_ff >= idle_lim_ff) begin
          nxt_state = PWR_SLEEP;
        end
      end
      // Mode 1 ignores attention; mode 2 ignores the request pin
      PWR_SLEEP: begin
        if (key_edge || bat_s2_ff) begin
          nxt_state = PWR_OFF;
        end else if (usb_fall || i_wake_event || i_msg_rx) begin
          nxt_state = PWR_NORMAL;
        end else if (mode_ff == SLEEP_CFG_PIN && dtr_cnt_ff >= DTR_LOW_N) begin
          nxt_state = PWR_NORMAL;
        end else if (mode_ff == SLEEP_CFG_AUTO && attn) begin
          nxt_state = PWR_NORMAL;
          nxt_resp  = 1'b1;
        end
      end
      default: begin
        nxt_state = PWR_OFF;
      end
    endcase
    // A change of state restarts the idle run, so a wake does not fall
    // straight back to sleep on an old count
    if (nxt_state != state_ff) begin
      nxt_idle_cnt = '0;
    end
  end

  // Power state registers; the idle limit starts at the module's default
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff    <= PWR_NORMAL;
      mode_ff     <= SLEEP_CFG_OFF;
      idle_lim_ff <= IDLE_INIT_N;
      idle_cnt_ff <= '0;
      dtr_cnt_ff  <= '0;
      resp_ff     <= 1'b0;
      urc_ff      <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      mode_ff     <= nxt_mode;
      idle_lim_ff <= nxt_idle_lim;
      idle_cnt_ff <= nxt_idle_cnt;
      dtr_cnt_ff  <= nxt_dtr_cnt;
      resp_ff     <= nxt_resp;
      urc_ff      <= nxt_urc;
    end
  end

  // Ring pulse; a new event restarts the full low time
  // It runs while we are awake too: the host may sleep when we do not
  always_comb begin
    nxt_ring_cnt = (ring_cnt_ff != '0) ? ring_cnt_ff - 1'b1 : '0;
    if (i_msg_rx && state_ff != PWR_OFF) begin
      nxt_ring_cnt = RING_N;
    end
  end

  // Ring counter register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ring_cnt_ff <= '0;
    end else begin
      ring_cnt_ff <= nxt_ring_cnt;
    end
  end

  // Outputs decode registered state only, so no pin reaches them directly
  assign link.host_wake_output = (ring_cnt_ff == '0);
  assign link.cmd_resp         = resp_ff;
  assign o_event_urc           = urc_ff;
  assign o_asleep              = (state_ff == PWR_SLEEP);
  assign o_powered             = (state_ff != PWR_OFF);
endmodule : sleep_wake_device

// File: design/sleep_wake_pkg.sv
package sleep_wake_pkg;
  // Clock rate and derived timing
  localparam int unsigned CLK_HZ           = 50000000;
  localparam int unsigned DTR_LOW_MS       = 50;
  localparam int unsigned DTR_LOW_CYC      = CLK_HZ / 1000 * DTR_LOW_MS;
  localparam int unsigned RING_PULSE_MS    = 120;
  localparam int unsigned RING_PULSE_CYC   = CLK_HZ / 1000 * RING_PULSE_MS;
  localparam int unsigned IDLE_DEFAULT_S   = 5;
  localparam int unsigned IDLE_DEFAULT_CYC = CLK_HZ * IDLE_DEFAULT_S;
  localparam int unsigned CNT_W            = 32;

  // Sleep-configuration parameter values
  localparam logic [1:0] SLEEP_CFG_OFF  = 2'h0;
  localparam logic [1:0] SLEEP_CFG_PIN  = 2'h1;
  localparam logic [1:0] SLEEP_CFG_AUTO = 2'h2;

  // Command codes on the serial strobe
  localparam logic [1:0] CMD_ATTN        = 2'h0;
  localparam logic [1:0] CMD_SLEEP_CFG   = 2'h1;
  localparam logic [1:0] CMD_TIMEOUT_CFG = 2'h2;

  // Power state, Gray along off -> normal -> sleep
  typedef enum logic [1:0] {
    PWR_OFF    = 2'b00,
    PWR_NORMAL = 2'b01,
    PWR_SLEEP  = 2'b11
  } pwr_state_type;
endpackage : sleep_wake_pkg

// File: design/sleep_wake_if.sv
`timescale 1ns/1ps
// Pins and link events between host and modem
interface sleep_wake_if;
  logic       sleep_req;        // Host drives high to request sleep (mode 1)
  logic       host_wake_output; // Modem ring/wake line, rests high
  logic       power_key_pin;    // Power key pulse from host
  logic       cmd_valid;        // Serial command strobe to modem
  logic [1:0] cmd_code;         // 0 attention, 1 sleep cfg, 2 timeout cfg
  logic [1:0] cmd_arg;          // Sleep cfg argument
  logic [31:0] cmd_timeout;     // Idle timeout in cycles
  logic       cmd_resp;         // Modem answered a command
  logic       usb_suspend;      // Host USB suspend level
  modport device (input sleep_req, power_key_pin, cmd_valid, cmd_code, cmd_arg,
                  cmd_timeout, usb_suspend, output host_wake_output, cmd_resp);
  modport host (output sleep_req, power_key_pin, cmd_valid, cmd_code, cmd_arg,
                cmd_timeout, usb_suspend, input host_wake_output, cmd_resp);
endinterface : sleep_wake_if

// File: design/sleep_wake_host.sv
`timescale 1ns/1ps
module sleep_wake_host
  import sleep_wake_pkg::*;
(
  input  wire logic        i_ref_clk,     // 50 MHz clock
  input  wire logic        i_rstn,        // Async reset, active low
  sleep_wake_if.host       link,          // Pins toward modem
  input  wire logic        i_sleep_req,   // User asks modem to sleep (mode 1)
  input  wire logic        i_power_key,   // User power key level
  input  wire logic        i_usb_suspend, // User USB suspend level
  input  wire logic        i_cmd_valid,   // User command strobe
  input  wire logic [1:0]  i_cmd_code,    // User command code
  input  wire logic [1:0]  i_cmd_arg,     // User sleep cfg argument
  input  wire logic [31:0] i_cmd_timeout, // User idle timeout
  input  wire logic        i_wake_mode2,  // Keep sending attention until answer
  output logic             o_cmd_resp,    // Modem answered
  output logic             o_ring         // Ring seen (wake line low)
);
  import sleep_wake_pkg::*;
  logic ring_s1_ff, ring_s2_ff, nxt_ring_s1, nxt_ring_s2;
  logic poll_ff, nxt_poll;

  // Attention polling until modem answers
  always_comb begin
    nxt_poll    = poll_ff;
    nxt_ring_s1 = link.host_wake_output;
    nxt_ring_s2 = ring_s1_ff;
    if (i_wake_mode2) begin
      nxt_poll = 1'b1;
    end else if (link.cmd_resp) begin
      nxt_poll = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      poll_ff    <= 1'b0;
      ring_s1_ff <= 1'b1;
      ring_s2_ff <= 1'b1;
    end else begin
      poll_ff    <= nxt_poll;
      ring_s1_ff <= nxt_ring_s1;
      ring_s2_ff <= nxt_ring_s2;
    end
  end

  // Sleep arming commands are user driven USB needs suspend support
  assign link.sleep_req     = i_sleep_req;
  assign link.power_key_pin = i_power_key;
  assign link.usb_suspend   = i_usb_suspend;
  assign link.cmd_valid     = i_cmd_valid | poll_ff;
  assign link.cmd_code      = poll_ff ? CMD_ATTN : i_cmd_code;
  assign link.cmd_arg       = i_cmd_arg;
  assign link.cmd_timeout   = i_cmd_timeout;
  assign o_cmd_resp         = link.cmd_resp;
  assign o_ring             = ~ring_s2_ff;
endmodule : sleep_wake_host

// File: test/sleep_wake_asserts.sv
`timescale 1ns/1ps
module sleep_wake_asserts #(
  parameter int unsigned DTR_LOW_N = 20, // Exit hold
  parameter int unsigned RING_N    = 30  // Ring width
) (
  input wire logic       i_ref_clk,        // Clock
  input wire logic       i_rstn,           // Reset
  input wire logic       sleep_req,        // Pin
  input wire logic       host_wake_output, // Ring
  input wire logic       cmd_valid,        // Strobe
  input wire logic [1:0] cmd_code,         // Code
  input wire logic [1:0] cmd_arg,          // Arg
  input wire logic       cmd_resp,         // Answer
  input wire logic       usb_suspend,      // Suspend
  input wire logic       i_msg_rx,         // Message
  input wire logic       o_asleep,         // Asleep
  input wire logic       o_powered         // Powered
);
  logic [1:0]  mode_ff, nxt_mode;
  logic [31:0] low_ff, nxt_low, req_ff, nxt_req;
  // Armed mode shadow; run lengths of low ring line and low pin
  always_comb begin
    nxt_mode = mode_ff;
    if (cmd_valid && cmd_code == 2'h1 && !o_asleep) nxt_mode = cmd_arg;
    if (!o_powered) nxt_mode = 2'h0;
    nxt_low = host_wake_output ? 32'h0 : low_ff + 32'h1;
    nxt_req = sleep_req ? 32'h0 : req_ff + 32'h1;
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_ff <= 2'h0;
      low_ff  <= 32'h0;
      req_ff  <= 32'h0;
    end else begin
      mode_ff <= nxt_mode;
      low_ff  <= nxt_low;
      req_ff  <= nxt_req;
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);
  // Answer first; leaving sleep may lag by the state register
  sequence s_answer;
    cmd_resp ##[0:2] !o_asleep;
  endsequence
  a_refuse_asleep: assert property (
    o_asleep && cmd_valid && cmd_code != 2'h0 |=> !cmd_resp) else $error("answer in sleep");
  a_attn_wake: assert property (
    o_asleep && mode_ff == 2'h2 && cmd_valid && cmd_code == 2'h0 |=> s_answer)
    else $error("no wake");
  a_pin_enter: assert property (
    mode_ff == 2'h1 && !o_asleep && $rose(sleep_req) |-> ##[2:4] o_asleep) else $error("no sleep");
  a_exit_hold: assert property (
    $fell(o_asleep) && mode_ff == 2'h1 && o_powered && !$past(i_msg_rx) |->
      req_ff >= DTR_LOW_N) else $error("early wake");
  // Pin low seen for the full hold: two sync stages and the state register follow
  a_exit_timely: assert property (
    mode_ff == 2'h1 && o_asleep && req_ff == DTR_LOW_N |-> ##3 !o_asleep)
    else $error("late wake");
  a_ring_width: assert property (
    $rose(host_wake_output) |-> low_ff == RING_N) else $error("ring width");
  a_ring_cause: assert property (
    $fell(host_wake_output) |-> $past(i_msg_rx)) else $error("stray ring");
  a_usb_sleep: assert property (
    o_powered && $rose(usb_suspend) |-> ##[1:4] o_asleep) else $error("no usb sleep");
  a_reset_state: assert property (
    $rose(i_rstn) |-> o_powered && !o_asleep && host_wake_output) else $error("reset state");
endmodule : sleep_wake_asserts

// File: test/sleep_wake_controller_tb_top.sv
`timescale 1ns/1ps
module sleep_wake_controller_tb_top;
  localparam int unsigned DTR_N  = 20; // Short exit hold
  localparam int unsigned RING_N = 30; // Short ring
  logic        i_ref_clk, i_rstn, i_sleep_req, i_power_key, i_usb_suspend, i_cmd_valid;
  logic        i_wake_mode2, i_power_on, i_batt_low, i_wake_event, i_msg_rx, got, urc, rng;
  logic        o_cmd_resp, o_ring, o_event_urc, o_asleep, o_powered, wok;
  logic [1:0]  i_cmd_code, i_cmd_arg;
  logic [31:0] i_cmd_timeout;
  int          err_total, tests_run, cnt;
  sleep_wake_if link_if ();
  sleep_wake_host i_sleep_wake_host (.i_ref_clk, .i_rstn, .link(link_if), .i_sleep_req,
    .i_power_key, .i_usb_suspend, .i_cmd_valid, .i_cmd_code, .i_cmd_arg, .i_cmd_timeout,
    .i_wake_mode2, .o_cmd_resp, .o_ring);
  sleep_wake_device #(.DTR_LOW_N(DTR_N), .RING_N(RING_N), .IDLE_INIT_N(50))
    i_sleep_wake_device (.i_ref_clk, .i_rstn, .link(link_if), .i_power_on, .i_batt_low,
    .i_wake_event, .i_msg_rx, .o_event_urc, .o_asleep, .o_powered);
  sleep_wake_asserts #(.DTR_LOW_N(DTR_N), .RING_N(RING_N)) i_sleep_wake_asserts (
    .i_ref_clk, .i_rstn, .sleep_req(link_if.sleep_req), .cmd_valid(link_if.cmd_valid),
    .host_wake_output(link_if.host_wake_output), .cmd_code(link_if.cmd_code),
    .cmd_arg(link_if.cmd_arg), .cmd_resp(link_if.cmd_resp), .usb_suspend(link_if.usb_suspend),
    .i_msg_rx, .o_asleep, .o_powered);
  // 50 MHz clock
  initial i_ref_clk = 1'b0;
  always #10 i_ref_clk = ~i_ref_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Wait n edges, then let that edge's updates land
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  // One command; the answer window is wider than the one-cycle latency on purpose
  task automatic cmd(input logic [1:0] c, input logic [1:0] a);
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_code  <= c;
    i_cmd_arg   <= a;
    @(posedge i_ref_clk) i_cmd_valid <= 1'b0;
    got = 1'b0;
    repeat (4) begin
      #1;
      if (o_cmd_resp === 1'b1) got = 1'b1;
      @(posedge i_ref_clk);
    end
  endtask : cmd
  // Message pulse; count ring-low cycles and sample sleep early in the pulse
  task automatic msg();
    @(posedge i_ref_clk) i_msg_rx <= 1'b1;
    @(posedge i_ref_clk) i_msg_rx <= 1'b0;
    cnt = 0;
    urc = 1'b0;
    rng = 1'b0;
    wok = 1'b1;
    repeat (RING_N + 10) begin
      #1;
      if (link_if.host_wake_output === 1'b0) cnt++;
      if (o_event_urc === 1'b1) urc = 1'b1;
      if (o_ring === 1'b1) rng = 1'b1;
      if (cnt == 4) wok = o_asleep;
      @(posedge i_ref_clk);
    end
  endtask : msg
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial begin
    {i_rstn, i_sleep_req, i_power_key, i_usb_suspend, i_cmd_valid, i_wake_mode2} = 6'h0;
    {i_power_on, i_batt_low, i_wake_event, i_msg_rx, i_cmd_code, i_cmd_arg} = 8'h0;
    i_cmd_timeout = 32'h3c;
    err_total = 0;
    tests_run = 0;
    repeat (5) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    tick(2);
    chk("powered", o_powered, 1);
    chk("asleep", o_asleep, 0);
    chk("ring idle", link_if.host_wake_output, 1);
    $display("test reset done");
    cmd(2'h1, 2'h1); chk("cfg1", got, 1);
    @(posedge i_ref_clk) i_sleep_req <= 1'b1;
    tick(6); chk("pin sleep", o_asleep, 1);
    cmd(2'h1, 2'h0); chk("refused", got, 0);
    @(posedge i_ref_clk) i_sleep_req <= 1'b0;
    tick(DTR_N - 8); chk("short low", o_asleep, 1);
    tick(15); chk("pin wake", o_asleep, 0);
    $display("test pin done");
    cmd(2'h2, 2'h0); chk("timeout", got, 1);
    cmd(2'h1, 2'h2); chk("cfg2", got, 1);
    tick(45); chk("idle short", o_asleep, 0);
    tick(40); chk("idle sleep", o_asleep, 1);
    @(posedge i_ref_clk) i_sleep_req <= 1'b1;
    tick(3);
    @(posedge i_ref_clk) i_sleep_req <= 1'b0;
    tick(DTR_N + 10); chk("pin ignored", o_asleep, 1);
    msg(); chk("ring width", cnt, RING_N);
    chk("report", urc, 1);
    chk("ring seen", rng, 1);
    chk("msg wake", wok, 0);
    tick(80); chk("resleep", o_asleep, 1);
    @(posedge i_ref_clk) i_wake_event <= 1'b1;
    @(posedge i_ref_clk) i_wake_event <= 1'b0;
    tick(3); chk("event wake", o_asleep, 0);
    tick(80);
    @(posedge i_ref_clk) i_wake_mode2 <= 1'b1;
    tick(8); chk("attn wake", o_asleep, 0);
    @(posedge i_ref_clk) i_wake_mode2 <= 1'b0;
    $display("test auto done");
    cmd(2'h1, 2'h0); chk("cfg off", got, 1);
    tick(100); chk("no auto", o_asleep, 0);
    @(posedge i_ref_clk) i_usb_suspend <= 1'b1;
    tick(5); chk("usb sleep", o_asleep, 1);
    @(posedge i_ref_clk) i_usb_suspend <= 1'b0;
    tick(5); chk("usb wake", o_asleep, 0);
    $display("test usb done");
    @(posedge i_ref_clk) i_power_key <= 1'b1;
    tick(5); chk("key off", o_powered, 0);
    @(posedge i_ref_clk) i_power_key <= 1'b0;
    @(posedge i_ref_clk) i_power_on <= 1'b1;
    @(posedge i_ref_clk) i_power_on <= 1'b0;
    tick(5); chk("boot", o_powered, 1);
    @(posedge i_ref_clk) i_usb_suspend <= 1'b1;
    tick(5); chk("usb resleep", o_asleep, 1);
    @(posedge i_ref_clk) i_batt_low <= 1'b1;
    tick(5); chk("batt off", o_powered, 0);
    $display("test power done");
    end_of_test();
  end
endmodule : sleep_wake_controller_tb_top
